// ==== hbsd_defines.svh ====
// hbsd_defines.svh: offsets, field positions, reset values and decode bounds of the host port
// assumes it is included by bare name from the block's source files
// Functional notes
// - decode 64K space from low sixteen address bits
// - offsets 0000 to 9fff reach display memory
// - offsets ffe0 to ffff reach register window
// - image repeats every 64K above bit 16
// - sample five straps once, hold until reset
// - select strap high byte-enable, low separate strobes
// - endian strap high big, low little
// - type straps 111 select generic family
// - asynchronous strobes synchronised before any use
// - byte-enable mode: hbe, read, write strobes
// - separate mode: two write, two read strobes
`ifndef HBSD_DEFINES_SVH
`define HBSD_DEFINES_SVH

// ****************************************
// host address decode
// ****************************************
`define HBSD_MEM_LAST 16'h9fff
`define HBSD_REG_FIRST 16'hffe0
`define HBSD_GENERIC_TYPE 3'h7
`define HBSD_ENDIAN_BIT 3

// ****************************************
// apb register offsets (byte addresses)
// ****************************************
`define HBSD_OFF_CTRL 12'h000
`define HBSD_OFF_STATUS 12'h004
`define HBSD_OFF_GAP 12'h008
`define HBSD_OFF_COUNT 12'h00c

// ****************************************
// field positions and reset values
// ****************************************
`define HBSD_CTRL_EN_BIT 0
`define HBSD_CTRL_ALIAS_BIT 1
`define HBSD_CTRL_EN_RST 1'h1
`define HBSD_CTRL_ALIAS_RST 1'h0
`define HBSD_GAP_RST 16'hffff
`define HBSD_STAT_SEL_BIT 5
`define HBSD_STAT_VALID_BIT 6
`define HBSD_STAT_GENERIC_BIT 7
`define HBSD_STAT_BUSY_BIT 8

`endif

// ==== hbsd_pkg.sv ====
// hbsd_pkg.sv: types of the host bus strap decode block
// assumes hbsd_defines.svh holds every numeric constant
package hbsd_pkg;

  // host port sequencer states
  typedef enum logic [1:0] {
    HBSD_IDLE = 2'b00,
    HBSD_WAIT = 2'b01,
    HBSD_HOLD = 2'b10
  } hbsd_state_t;

  // all state of the top module
  typedef struct packed {
    hbsd_state_t st;
    logic cfg_valid;
    logic [4:0] straps;
    logic sel_strap;
    logic generic_fam; // type straps select the generic family
    logic en;
    logic alias_blk;
    logic [15:0] gap_val;
    logic [15:0] mem_cnt;
    logic [15:0] gap_cnt;
    logic acc_mem;
    logic acc_reg;
    logic acc_we;
    logic [15:0] acc_addr;
    logic [1:0] acc_be;
    logic [15:0] acc_wdata;
    logic [15:0] hrdata;
    logic hdata_oe_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hbsd_regs_t;

endpackage

// ==== hbsd_sync.sv ====
// hbsd_sync.sv: two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level, not a bus of related bits
`timescale 1ns/10ps
`default_nettype none

module hbsd_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // first stage, read only by the second
  logic [W-1:0] meta_q;

  // ****************************************
  // two stage capture
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // hbsd_sync

`default_nettype wire

// ==== hbsd_top.sv ====
// hbsd_top.sv: host bus front end with strap capture, strobe decode, 64K decode and apb registers
// assumes host address and write data stable while a strobe is active; memory answers within the pulse cycle
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "hbsd_defines.svh"

module hbsd_top #(
  parameter int HADDR_W = 26
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power-up straps
  input wire logic [4:0] config_straps,
  input wire logic interface_select_strap,
  // asynchronous host strobes, active low
  input wire logic low_byte_write_strobe_n,
  input wire logic high_byte_write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic rd_wr_n,
  // host address and data bus
  input wire logic [HADDR_W-1:0] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe_n,
  // internal access port toward display memory and registers
  output logic acc_mem,
  output logic acc_reg,
  output logic acc_we,
  output logic [15:0] acc_addr,
  output logic [1:0] acc_be,
  output logic [15:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  // captured configuration
  output logic cfg_big_endian,
  output logic cfg_byte_enable_mode,
  output logic cfg_generic
);

  // ****************************************
  // declarations
  // ****************************************
  hbsd_pkg::hbsd_regs_t s_q; // registered state
  hbsd_pkg::hbsd_regs_t s_d; // next state
  logic [3:0] strb_s; // synchronised strobes {rd_wr, rd, we1, we0}
  logic [1:0] wr_be; // active write byte lanes {high, low}
  logic [1:0] rd_be; // active read byte lanes {high, low}
  logic any_act; // some read or write strobe active
  logic start; // access may begin this cycle
  logic blocked; // upper bits nonzero with aliasing off
  logic in_mem; // decode hits display memory
  logic in_reg; // decode hits register window
  logic big; // big endian selected
  logic generic_ok; // generic family selected
  logic apb_wr; // apb write takes effect
  logic [15:0] lo_addr; // low sixteen host address bits

  // ****************************************
  // strobe synchroniser
  // ****************************************
  // strobe synchronisation
  hbsd_sync #(
    .W(4),
    .RST_VAL(4'hf)
  ) hbsd_sync_inst (
    .clk(pclk),
    .rst_n(presetn),
    .d({rd_wr_n, read_strobe_n, high_byte_write_strobe_n, low_byte_write_strobe_n}),
    .q(strb_s)
  );

  // ****************************************
  // strobe role and address decode
  // ****************************************
  always_comb begin
    big = s_q.straps[`HBSD_ENDIAN_BIT];
    generic_ok = (s_q.straps[2:0] == `HBSD_GENERIC_TYPE);
    if (s_q.sel_strap) begin
      wr_be = {~strb_s[1], ~host_addr[0]} & {2{~strb_s[0]}};
      rd_be = {~strb_s[1], ~host_addr[0]} & {2{~strb_s[2]}};
    end else begin
      wr_be = {~strb_s[1], ~strb_s[0]};
      rd_be = {~strb_s[3], ~strb_s[2]};
    end
    any_act = |{wr_be, rd_be};
    start = (s_q.st == hbsd_pkg::HBSD_IDLE) && s_q.cfg_valid && generic_ok && s_q.en && any_act;
    lo_addr = host_addr[15:0];
    blocked = s_q.alias_blk && (|host_addr[HADDR_W-1:16]);
    in_mem = (lo_addr <= `HBSD_MEM_LAST) && !blocked;
    in_reg = (lo_addr >= `HBSD_REG_FIRST) && !blocked;
    apb_wr = psel && penable && pwrite && s_q.pready;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.acc_mem = 1'b0;
    s_d.acc_reg = 1'b0;
    if (!s_q.cfg_valid) begin
      s_d.cfg_valid = 1'b1;
      s_d.straps = config_straps;
      s_d.sel_strap = interface_select_strap;
      s_d.generic_fam = (config_straps[2:0] == `HBSD_GENERIC_TYPE);
    end
    // apb answer is always zero wait
    s_d.pready = psel && !penable;
    if (psel && !penable) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      case (paddr)
        `HBSD_OFF_CTRL: begin
          s_d.prdata[`HBSD_CTRL_EN_BIT] = s_q.en;
          s_d.prdata[`HBSD_CTRL_ALIAS_BIT] = s_q.alias_blk;
        end
        `HBSD_OFF_STATUS: begin
          s_d.prdata[4:0] = s_q.straps;
          s_d.prdata[`HBSD_STAT_SEL_BIT] = s_q.sel_strap;
          s_d.prdata[`HBSD_STAT_VALID_BIT] = s_q.cfg_valid;
          s_d.prdata[`HBSD_STAT_GENERIC_BIT] = generic_ok;
          s_d.prdata[`HBSD_STAT_BUSY_BIT] = (s_q.st != hbsd_pkg::HBSD_IDLE);
        end
        `HBSD_OFF_GAP: begin
          s_d.prdata[15:0] = s_q.gap_val;
        end
        `HBSD_OFF_COUNT: begin
          s_d.prdata = {s_q.gap_cnt, s_q.mem_cnt};
        end
        default: begin
          // unmapped offset answers with an error
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // apb writes to the writable registers
    if (apb_wr) begin
      case (paddr)
        `HBSD_OFF_CTRL: begin
          s_d.en = pwdata[`HBSD_CTRL_EN_BIT];
          s_d.alias_blk = pwdata[`HBSD_CTRL_ALIAS_BIT];
        end
        `HBSD_OFF_GAP: begin
          s_d.gap_val = pwdata[15:0];
        end
        default: begin
          // read-only or unmapped: no effect
        end
      endcase
    end
    // host access sequencer
    case (s_q.st)
      hbsd_pkg::HBSD_IDLE: begin
        if (start) begin
          s_d.acc_addr = lo_addr;
          s_d.acc_we = |wr_be;
          s_d.acc_be = big ? {(|wr_be ? wr_be[0] : rd_be[0]), (|wr_be ? wr_be[1] : rd_be[1])}
                           : (|wr_be ? wr_be : rd_be);
          s_d.acc_wdata = big ? {host_data_in[7:0], host_data_in[15:8]} : host_data_in;
          if (in_mem || in_reg) begin
            s_d.acc_mem = in_mem;
            s_d.acc_reg = in_reg;
            s_d.mem_cnt = s_q.mem_cnt + 16'h0001;
            s_d.st = (|wr_be) ? hbsd_pkg::HBSD_HOLD : hbsd_pkg::HBSD_WAIT;
          end else begin
            s_d.gap_cnt = s_q.gap_cnt + 16'h0001;
            if (!(|wr_be)) begin
              s_d.hrdata = s_q.gap_val;
              s_d.hdata_oe_n = 1'b0;
            end
            s_d.st = hbsd_pkg::HBSD_HOLD;
          end
        end
      end
      hbsd_pkg::HBSD_WAIT: begin
        // memory data is taken at the end of the pulse cycle
        s_d.hrdata = big ? {acc_rdata[7:0], acc_rdata[15:8]} : acc_rdata;
        s_d.hdata_oe_n = 1'b0;
        s_d.st = hbsd_pkg::HBSD_HOLD;
      end
      hbsd_pkg::HBSD_HOLD: begin
        // wait until no read or write strobe is active (hbe alone does not hold the state)
        if (!any_act) begin
          s_d.hdata_oe_n = 1'b1;
          s_d.st = hbsd_pkg::HBSD_IDLE;
        end
      end
      default: begin
        s_d.hdata_oe_n = 1'b1;
        s_d.st = hbsd_pkg::HBSD_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.en <= `HBSD_CTRL_EN_RST;
      s_q.alias_blk <= `HBSD_CTRL_ALIAS_RST;
      s_q.gap_val <= `HBSD_GAP_RST;
      s_q.hdata_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign host_data_out = s_q.hrdata;
  assign host_data_oe_n = s_q.hdata_oe_n;
  assign acc_mem = s_q.acc_mem;
  assign acc_reg = s_q.acc_reg;
  assign acc_we = s_q.acc_we;
  assign acc_addr = s_q.acc_addr;
  assign acc_be = s_q.acc_be;
  assign acc_wdata = s_q.acc_wdata;
  assign cfg_big_endian = s_q.straps[`HBSD_ENDIAN_BIT];
  assign cfg_byte_enable_mode = s_q.sel_strap;
  assign cfg_generic = s_q.generic_fam;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a read that starts with neither range decoded (gap address or blocked alias)
  sequence seq_gap_read_start;
    start && !(|wr_be) && !in_mem && !in_reg;
  endsequence

  // an unblocked start into display memory
  sequence seq_mem_start;
    start && !s_q.alias_blk && (lo_addr <= `HBSD_MEM_LAST);
  endsequence

  AST_MEM_RANGE: assert property (acc_mem |-> acc_addr <= `HBSD_MEM_LAST)
    else $error("memory pulse outside memory range");

  AST_REG_RANGE: assert property (acc_reg |-> acc_addr >= `HBSD_REG_FIRST)
    else $error("register pulse outside register window");

  AST_LOW_BITS: assert property (seq_mem_start |=> acc_mem && acc_addr == $past(host_addr[15:0]))
    else $error("memory start not decoded from low address bits");

  AST_ALIAS_BLOCK: assert property (start && s_q.alias_blk && (|host_addr[HADDR_W-1:16])
                                    |=> !acc_mem && !acc_reg)
    else $error("blocked alias reached memory or registers");

  AST_STRAP_HOLD: assert property (s_q.cfg_valid && $past(s_q.cfg_valid) |-> $stable(s_q.straps)
                                   && $stable(s_q.sel_strap))
    else $error("strap configuration changed after capture");

  AST_GENERIC_ONLY: assert property ((acc_mem || acc_reg) |-> cfg_generic)
    else $error("access taken without generic family straps");

  AST_SYNC_DELAY: assert property ($rose(acc_mem || acc_reg) |-> $past(!read_strobe_n || !low_byte_write_strobe_n
                                   || !high_byte_write_strobe_n || !rd_wr_n, 3))
    else $error("access without a strobe three cycles earlier");

  AST_BIG_ENDIAN: assert property ((acc_mem || acc_reg) && acc_we && cfg_big_endian
                                   |-> acc_wdata == {$past(host_data_in[7:0]), $past(host_data_in[15:8])})
    else $error("big endian write data not byte swapped");

  AST_BE_MODE: assert property ((acc_mem || acc_reg) && acc_we && cfg_byte_enable_mode && !cfg_big_endian
                                |-> acc_be[1] == !$past(strb_s[1]))
    else $error("high byte enable not taken from its pin");

  AST_SEP_READ: assert property ((acc_mem || acc_reg) && !acc_we && !cfg_byte_enable_mode
                                 |-> acc_be == (cfg_big_endian ? {!$past(strb_s[2]), !$past(strb_s[3])}
                                                               : {!$past(strb_s[3]), !$past(strb_s[2])}))
    else $error("separate read strobes not mapped to lanes");

  AST_GAP_READ: assert property (seq_gap_read_start |=> !host_data_oe_n && host_data_out == $past(s_q.gap_val)
                                 && !acc_mem && !acc_reg)
    else $error("gap read did not return the fixed value");

  // read data handed back after a memory or register read
  sequence seq_data_return;
    $fell(host_data_oe_n) && $past(s_q.st == hbsd_pkg::HBSD_WAIT);
  endsequence

  AST_READ_DATA: assert property (seq_data_return |-> host_data_out == (cfg_big_endian ?
                                  {$past(acc_rdata[7:0]), $past(acc_rdata[15:8])} : $past(acc_rdata)))
    else $error("read data not taken from memory in host byte order");

  AST_REG_HIT: assert property (start && !s_q.alias_blk && (lo_addr >= `HBSD_REG_FIRST)
                                |=> acc_reg && !acc_mem && acc_addr == $past(lo_addr))
    else $error("register window start not sent to registers");

  AST_GAP_WRITE: assert property (start && (|wr_be) && !in_mem && !in_reg
                                  |=> !acc_mem && !acc_reg && host_data_oe_n)
    else $error("gap write reached memory or drove the bus");

  AST_PULSE_ONE: assert property ((acc_mem || acc_reg) |=> !acc_mem && !acc_reg)
    else $error("access pulse longer than one cycle");

  AST_CAPTURE_FIRST: assert property ($rose(s_q.cfg_valid)
                                      |-> s_q.straps == $past(config_straps)
                                      && s_q.sel_strap == $past(interface_select_strap))
    else $error("straps not captured at the first edge after reset");

  AST_BE_READ: assert property ((acc_mem || acc_reg) && !acc_we && cfg_byte_enable_mode
                                && !cfg_big_endian |-> acc_be == {!$past(strb_s[1]), !$past(host_addr[0])})
    else $error("byte-enable read lanes not taken from high enable and address");

  AST_SEP_WRITE: assert property ((acc_mem || acc_reg) && acc_we && !cfg_byte_enable_mode
                                  |-> acc_be == (cfg_big_endian ? {!$past(strb_s[0]), !$past(strb_s[1])}
                                                                : {!$past(strb_s[1]), !$past(strb_s[0])}))
    else $error("separate write strobes not mapped to lanes");

endmodule // hbsd_top

`default_nettype wire

// ==== hbsd_host_model.sv ====
// hbsd_host_model.sv: host model issuing strobe cycles, plus a display memory and register responder
// assumes the bench pulses go for one cycle, holds the command and then waits for done
`timescale 1ns/10ps
`default_nettype none
module hbsd_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from the bench
  input wire logic go,
  input wire logic rd,
  input wire logic be_mode,
  input wire logic [25:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  // host side pins
  output logic low_byte_write_strobe_n,
  output logic high_byte_write_strobe_n,
  output logic read_strobe_n,
  output logic rd_wr_n,
  output logic [25:0] host_addr,
  output logic [15:0] host_data_in,
  // access port answer
  input wire logic acc_rd,
  input wire logic [15:0] acc_addr,
  output logic [15:0] acc_rdata
);
  logic [4:0] cnt_q; // cycle within an access, zero when idle
  // ****************
  // strobe sequencer: the selected strobes fall together and all strobes rise together
  // ****************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      done <= 1'b0;
      {low_byte_write_strobe_n, high_byte_write_strobe_n, read_strobe_n, rd_wr_n} <= 4'hf;
      host_addr <= 26'h0000000;
      host_data_in <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (go) begin
        cnt_q <= 5'h01;
        host_addr <= addr;
        host_data_in <= wdata;
        // only the strobes of this access fall, the rest stay high
        low_byte_write_strobe_n <= rd;
        high_byte_write_strobe_n <= be_mode ? 1'b0 : rd;
        read_strobe_n <= !rd;
        rd_wr_n <= be_mode ? 1'b1 : !rd;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q + 5'h01;
        // release strobes, bus no longer holds the data
        if (cnt_q == 5'h08) begin
          {low_byte_write_strobe_n, high_byte_write_strobe_n, read_strobe_n, rd_wr_n} <= 4'hf;
          host_data_in <= ~host_data_in;
        end
        // idle long enough for the port to see the release
        if (cnt_q == 5'h0e) begin
          done <= 1'b1;
          cnt_q <= 5'h00;
        end
      end
    end
  end
  logic [15:0] junk_q; // toggling filler shown while no read is pending
  // filler toggles every cycle so a stale capture is caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) junk_q <= 16'h0000;
    else junk_q <= ~junk_q;
  end
  // memory answer stands during the read pulse, filler otherwise
  assign acc_rdata = acc_rd ? (acc_addr ^ 16'h5a5a) : junk_q;
endmodule // hbsd_host_model
`default_nettype wire

// ==== hbsd_top_tb_top.sv ====
// hbsd_top_tb_top.sv: self-checking bench of the host bus strap decode block
// assumes hbsd_top with its default parameters and the host model beside it
`timescale 1ns/10ps
`default_nettype none
`define HBSD_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module hbsd_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oe_n, sel, big;
  logic oe_d = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  logic [31:0] cyc = 32'h0;
  logic [4:0] straps;
  logic wl_n, wh_n, r_n, rw_n, h_go, h_rd, h_done, a_mem, a_reg, a_we, c_big, c_be, c_gen;
  logic [25:0] h_addr, haddr;
  logic [15:0] h_wd, hdin, hdout, a_addr, a_wd, a_rd, gv;
  logic [1:0] a_be;
  logic [43:0] expq[$];
  int n_errors, samples_checked;
  logic [15:0] offs [6] = '{16'h0000, 16'h9fff, 16'hffe0, 16'hffff, 16'ha000, 16'hffdf};
  hbsd_top hbsd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_straps(straps), .interface_select_strap(sel), .low_byte_write_strobe_n(wl_n),
    .high_byte_write_strobe_n(wh_n), .read_strobe_n(r_n), .rd_wr_n(rw_n), .host_addr(haddr),
    .host_data_in(hdin), .host_data_out(hdout), .host_data_oe_n(oe_n), .acc_mem(a_mem), .acc_reg(a_reg),
    .acc_we(a_we), .acc_addr(a_addr), .acc_be(a_be), .acc_wdata(a_wd), .acc_rdata(a_rd),
    .cfg_big_endian(c_big), .cfg_byte_enable_mode(c_be), .cfg_generic(c_gen));
  hbsd_host_model hbsd_host_model_inst (.pclk(pclk), .presetn(presetn), .go(h_go), .rd(h_rd), .be_mode(sel),
    .addr(h_addr), .wdata(h_wd), .done(h_done), .low_byte_write_strobe_n(wl_n), .high_byte_write_strobe_n(wh_n),
    .read_strobe_n(r_n), .rd_wr_n(rw_n), .host_addr(haddr), .host_data_in(hdin),
    .acc_rd((a_mem | a_reg) & ~a_we), .acc_addr(a_addr), .acc_rdata(a_rd));
  // ****************
  // helpers
  // ****************
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [15:0] sw(input logic [15:0] x);
    return big ? {x[7:0], x[15:8]} : x;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [43:0] g);
    logic [43:0] e;
    if (expq.size() == 0) begin
      n_errors++;
      $display("wrong value event expected none seen %h", g);
    end else begin
      e = expq.pop_front();
      `HBSD_CHK("event", e, g)
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // kind 0 ignored, 1 decoded, 2 gap
  task automatic host_op(input logic r, input logic [25:0] a, input logic [15:0] d, input int k);
    logic [1:0] be;
    be = sel ? {1'b1, ~a[0]} : 2'b11;
    if (big) be = {be[0], be[1]};
    if (k == 1) expq.push_back({4'h1, a[15:0] <= 16'h9fff, a[15:0] > 16'h9fff, ~r, be, 3'h0, a[15:0], r ? 16'h0000 : sw(d)});
    if (r && k == 1) expq.push_back({4'h2, 24'h000000, sw(a[15:0] ^ 16'h5a5a)});
    if (r && k == 2) expq.push_back({4'h2, 24'h000000, gv});
    h_rd <= r; h_addr <= a; h_wd <= d; h_go <= 1'b1;
    @(posedge pclk);
    h_go <= 1'b0;
    while (h_done !== 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic do_reset(input logic [4:0] s, input logic sl);
    presetn <= 1'b0; straps <= s; sel <= sl; big <= s[3];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // ****************
  // clock, timeout and result monitor
  // ****************
  // core and bus clocks share one source here
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 32'h1;
    oe_d <= oe_n;
    if (cyc == 32'h1388) begin
      n_errors++;
      test_done();
    end
    if (presetn) begin
      if ((a_mem | a_reg) === 1'b1) chk({4'h1, a_mem, a_reg, a_we, a_be, 3'h0, a_addr, a_we ? a_wd : 16'h0000});
      if (oe_d === 1'b1 && oe_n === 1'b0) chk({4'h2, 24'h000000, hdout});
      if ((psel & penable & pready & ~pwrite) === 1'b1) chk({4'h3, 7'h00, pslverr, prdata});
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    {presetn, psel, penable, pwrite, h_go, h_rd} = 6'h00;
    paddr = 12'h000; pwdata = 32'h0; h_addr = 26'h0; h_wd = 16'h0;
    straps = 5'h07; sel = 1'b1; big = 1'b0; gv = 16'hffff; rs = 32'h00012b0f;
    do_reset(5'h07, 1'b1);
    `HBSD_CHK("cfg", 3'b011, {c_big, c_be, c_gen})
    straps <= 5'h18; sel <= 1'b0;
    repeat (3) @(posedge pclk);
    `HBSD_CHK("cfg held", 3'b011, {c_big, c_be, c_gen})
    expq.push_back({4'h3, 7'h00, 1'b0, 32'h000000e7});
    apb(1'b0, 12'h004, 32'h0);
    expq.push_back({4'h3, 7'h00, 1'b1, 32'h0});
    apb(1'b0, 12'h010, 32'h0);
    gv = rnd();
    apb(1'b1, 12'h008, {16'h0000, gv});
    expq.push_back({4'h3, 7'h00, 1'b0, 16'h0000, gv});
    apb(1'b0, 12'h008, 32'h0);
    sel <= 1'b1;
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      h_wd = rnd();
      h_addr = {rnd(), offs[i]};
      host_op(1'b0, h_addr, h_wd, i < 4 ? 1 : 2);
      host_op(1'b1, h_addr, h_wd, i < 4 ? 1 : 2);
    end
    // eight decoded and four gap accesses so far
    expq.push_back({4'h3, 7'h00, 1'b0, 32'h00040008});
    apb(1'b0, 12'h00c, 32'h0);
    host_op(1'b1, {2'h1, 8'h5c, 16'h0010}, 16'h0, 1);
    $display("test decode done");
    apb(1'b1, 12'h000, 32'h3);
    expq.push_back({4'h3, 7'h00, 1'b0, 32'h00000003});
    apb(1'b0, 12'h000, 32'h0);
    host_op(1'b1, {10'h001, 16'h0010}, 16'h0, 2);
    host_op(1'b1, {10'h000, 16'h0010}, 16'h0, 1);
    apb(1'b1, 12'h000, 32'h0);
    host_op(1'b1, 26'h0000020, 16'h0, 0);
    apb(1'b1, 12'h000, 32'h1);
    $display("test alias done");
    do_reset(5'h0f, 1'b0);
    `HBSD_CHK("cfg", 3'b101, {c_big, c_be, c_gen})
    host_op(1'b0, {10'h2aa, 16'h1234}, rnd(), 1);
    host_op(1'b1, {10'h2aa, 16'hfff0}, 16'h0, 1);
    $display("test separate done");
    do_reset(5'h03, 1'b1);
    `HBSD_CHK("cfg", 1'b0, c_gen)
    host_op(1'b1, 26'h0000040, 16'h0, 0);
    $display("test nongeneric done");
    if (expq.size() != 0) begin
      n_errors++;
      $display("wrong value pending events expected 0 seen %0d", expq.size());
    end
    test_done();
  end
endmodule // hbsd_top_tb_top
`default_nettype wire
